// ==== jtx_link.sv ====
`timescale 1ns/1ps
module jtx_link
  import jtx_pkg::*;
(
  input  wire logic              sys_clk_in,             // Device clock
  input  wire logic              rst_b_in,               // Async reset
  input  wire logic              sysref_in,              // SYSREF pin
  input  wire logic              link_sync_request_n_in, // Sync request
  input  wire logic [15:0]       sample_data_in,         // Converter word
  output logic                   sample_take_out,        // Word taken
  input  wire logic [ADDR_W-1:0] reg_addr_in,            // Reg address
  input  wire logic [DATA_W-1:0] reg_wdata_in,           // Write data
  input  wire logic              reg_wr_in,              // Write strobe
  input  wire logic              reg_rd_in,              // Read strobe
  output logic [DATA_W-1:0]      reg_rdata_out,          // Read data
  output logic [SYM_W-1:0]       lane_symbol_out,        // 10b symbol
  output logic                   link_up_out             // Data phase
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [10:0] enc_8b10b(input jtx_oct_t o,
                                            input logic     rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic       rd6;
    logic       alt;
    logic       unb4;
    x    = o.val[4:0];
    y    = o.val[7:5];
    c6   = o.is_k ? K28_6B : ENC6[x];
    rd6  = rd ^ ($countones(c6) != 3);
    if (rd && (($countones(c6) != 3) || (!o.is_k && x == 5'h07))) begin
      c6 = ~c6;
    end
    alt  = (y == 3'h7) && (o.is_k ||
           (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
           (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    c4   = alt ? ALT7_4B : ENC4[y];
    unb4 = ($countones(c4) != 2);
    if (unb4 || y == 3'h3) begin
      if (rd6) begin
        c4 = ~c4;
      end
    end else if (o.is_k && !rd6) begin
      c4 = ~c4;
    end
    return {rd6 ^ unb4, c6, c4};
  endfunction

  function automatic logic [22:0] scr_octet(input logic [7:0]  d,
                                            input logic [14:0] st);
    logic [14:0] s;
    logic [7:0]  q;
    s = st;
    q = '0;
    for (int i = 7; i >= 0; i--) begin
      q[i] = d[i] ^ s[14] ^ s[13];
      s    = {s[13:0], q[i]};
    end
    return {s, q};
  endfunction

  function automatic logic [32:0] prbs_word(input logic [22:0] st,
                                            input jtx_mode_t   m);
    logic [22:0] s;
    logic [9:0]  b;
    logic        fb;
    s = st;
    b = '0;
    for (int i = SYM_W - 1; i >= 0; i--) begin
      unique case (m)
        MODE_PRBS7:  fb = s[6] ^ s[5];
        MODE_PRBS15: fb = s[14] ^ s[13];
        default:     fb = s[22] ^ s[17];
      endcase
      s    = {s[21:0], fb};
      b[i] = fb;
    end
    // Longer sequences are sent inverted
    if (m != MODE_PRBS7) begin
      b = ~b;
    end
    return {s, b};
  endfunction

  function automatic logic is_prbs(input jtx_mode_t m);
    return m == MODE_PRBS7 || m == MODE_PRBS15 || m == MODE_PRBS23;
  endfunction

  function automatic logic [0:ILA_CFG_OCTETS-1][7:0] ila_cfg(
    input logic [4:0] k_m1,
    input logic       scr);
    return {ILA_ZERO, ILA_ZERO, ILA_ZERO, {scr, 2'h0, ILA_L_ENC},
            ILA_F_ENC, {3'h0, k_m1}, ILA_M_ENC, {3'h0, ILA_N_ENC},
            {ILA_SUBCV, ILA_NP_ENC}, {ILA_JESDV, ILA_S_ENC},
            ILA_ZERO, ILA_ZERO, ILA_ZERO,
            8'(FCHK_BASE + {3'h0, k_m1} + {7'h0, scr})};
  endfunction

  function automatic logic [5:0] clamp_k(input logic [5:0] v);
    return (v < K_MIN) ? K_MIN : ((v > K_MAX) ? K_MAX : v);
  endfunction

  // ****************************************************************
  // Signals
  // ****************************************************************
  jtx_cfg_t            cfg;
  jtx_state_t          state;
  jtx_state_t          next_state;
  jtx_oct_t            cur;
  logic [1:0]          mf_cnt;
  logic [1:0]          next_mf_cnt;
  logic [5:0]          oct_cnt;
  logic [4:0]          k_m1;
  logic [5:0]          lmfc_end;
  logic                lmfc_last;
  logic                sync_meta;
  logic                sync_s;
  logic                sysref_meta;
  logic                sysref_s;
  logic                sysref_d;
  logic                sysref_rise;
  logic                realign;
  logic                realign_seen;
  logic [3:0]          sync_lo_cnt;
  logic                sync_req;
  logic [15:0]         data_word;
  logic [14:0]         scr_st;
  logic [14:0]         next_scr_st;
  logic                scr_used;
  logic [22:0]         prbs_st;
  logic [32:0]         prbs_nx;
  logic                rd;
  logic [10:0]         enc;
  logic [0:ILA_CFG_OCTETS-1][7:0] cfg_oct;
  logic [5:0]          cfg_idx;
  logic [22:0]         scr_res;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg <= '{scr_en: 1'b0, mode: MODE_NORMAL, k_frames: K_RST,
               ramp_step: RAMP_RST};
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        REG_CTRL: begin
          cfg.scr_en <= reg_wdata_in[CTRL_SCR_BIT];
          cfg.mode   <= jtx_mode_t'(reg_wdata_in[CTRL_MODE_LSB +: MODE_W]);
        end
        // K held within its legal range
        REG_KCFG: cfg.k_frames  <= clamp_k(reg_wdata_in[K_W-1:0]);
        REG_RAMP: cfg.ramp_step <= reg_wdata_in[STEP_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      realign_seen <= 1'b0;
    end else if (realign) begin
      realign_seen <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == REG_STAT &&
                 reg_wdata_in[STAT_REALIGN_BIT]) begin
      realign_seen <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          REG_CTRL: begin
            reg_rdata_out[CTRL_SCR_BIT]               <= cfg.scr_en;
            reg_rdata_out[CTRL_MODE_LSB +: MODE_W]    <= cfg.mode;
          end
          REG_KCFG: reg_rdata_out[K_W-1:0]    <= cfg.k_frames;
          REG_RAMP: reg_rdata_out[STEP_W-1:0] <= cfg.ramp_step;
          REG_STAT: begin
            reg_rdata_out[STAT_STATE_LSB +: 2] <= state;
            reg_rdata_out[STAT_MF_LSB +: 2]    <= mf_cnt;
            reg_rdata_out[STAT_SYNC_BIT]       <= sync_s;
            reg_rdata_out[STAT_REALIGN_BIT]    <= realign_seen;
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // SYSREF and sync request each pass two flops on the device clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_meta   <= 1'b1;
      sync_s      <= 1'b1;
      sysref_meta <= 1'b0;
      sysref_s    <= 1'b0;
      sysref_d    <= 1'b0;
    end else begin
      sync_meta   <= link_sync_request_n_in;
      sync_s      <= sync_meta;
      sysref_meta <= sysref_in;
      sysref_s    <= sysref_meta;
      sysref_d    <= sysref_s;
    end
  end

  assign sysref_rise = sysref_s && !sysref_d;
  assign realign     = sysref_rise && (oct_cnt != SYSREF_LMFC_DLY);

  // Low time counted in octet cycles, short pulses ignored
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_lo_cnt <= '0;
    end else if (sync_s) begin
      sync_lo_cnt <= '0;
    end else if (sync_lo_cnt != SYNC_MIN_CYC) begin
      sync_lo_cnt <= sync_lo_cnt + 4'h1;
    end
  end

  assign sync_req = (sync_lo_cnt == SYNC_MIN_CYC) && !sync_s;

  // ****************************************************************
  // Frame and multiframe counters
  // ****************************************************************
  assign k_m1      = 5'(cfg.k_frames - K_ENC_OFS);
  assign lmfc_end  = {k_m1, 1'b1};
  assign lmfc_last = (oct_cnt >= lmfc_end);

  // Free-running from reset with an arbitrary phase
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oct_cnt <= '0;
    end else if (realign) begin
      oct_cnt <= SYSREF_LMFC_NEXT;
    end else if (lmfc_last) begin
      oct_cnt <= '0;
    end else begin
      oct_cnt <= oct_cnt + 6'h01;
    end
  end

  // ****************************************************************
  // Link state machine
  // ****************************************************************
  always_comb begin
    next_state  = state;
    next_mf_cnt = mf_cnt;
    unique case (state)
      // ILA begins on the LMFC boundary after release
      ST_CGS: begin
        if (sync_s && lmfc_last) begin
          next_state  = ST_ILA;
          next_mf_cnt = '0;
        end
      end
      // Four multiframes, then data or repeat
      ST_ILA: begin
        if (lmfc_last) begin
          next_mf_cnt = mf_cnt + 2'h1;
          if (mf_cnt == ILA_LAST_MF && cfg.mode != MODE_ILA_RPT) begin
            next_state = ST_DATA;
          end
        end
      end
      ST_DATA: ;
      default: next_state = ST_CGS;
    endcase
    // Realignment or held request drops the link
    if (sync_req || realign) begin
      next_state = ST_CGS;
    end
  end

  // Link always comes up through CGS and ILA
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state  <= ST_CGS;
      mf_cnt <= '0;
    end else begin
      state  <= next_state;
      mf_cnt <= next_mf_cnt;
    end
  end

  assign link_up_out = (state == ST_DATA);

  // ****************************************************************
  // Sample and ramp source
  // ****************************************************************
  assign sample_take_out = oct_cnt[0] && (cfg.mode != MODE_RAMP);

  // One 16-bit word per two-octet frame
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_word <= '0;
    end else if (oct_cnt[0]) begin
      if (cfg.mode != MODE_RAMP) begin
        data_word <= sample_data_in;
      end else if (state == ST_DATA) begin
        data_word <= data_word + cfg.ramp_step;
      end else begin
        data_word <= '0;
      end
    end
  end

  // ****************************************************************
  // Octet selection and scrambling
  // ****************************************************************
  assign cfg_oct = ila_cfg(k_m1, cfg.scr_en);
  assign cfg_idx = 6'(oct_cnt - 6'(ILA_CFG_START));
  assign scr_res = scr_octet(oct_cnt[0] ? data_word[7:0]
                                        : data_word[15:8], scr_st);

  always_comb begin
    cur         = '{is_k: 1'b1, val: K28_5};
    scr_used    = 1'b0;
    next_scr_st = scr_st;
    unique case (state)
      ST_CGS: ;
      ST_ILA: begin
        if (oct_cnt == ILA_R_POS) begin
          cur.val = K28_0;
        end else if (lmfc_last) begin
          cur.val = K28_3;
        end else if (mf_cnt == ILA_CFG_MF && oct_cnt == ILA_Q_POS) begin
          cur.val = K28_4;
        end else if (mf_cnt == ILA_CFG_MF &&
                     cfg_idx < 6'(ILA_CFG_OCTETS)) begin
          cur = '{is_k: 1'b0, val: cfg_oct[cfg_idx[3:0]]};
        end else begin
          cur = '{is_k: 1'b0, val: {2'h0, oct_cnt}};
        end
      end
      ST_DATA: begin
        cur.is_k = 1'b0;
        cur.val  = oct_cnt[0] ? data_word[7:0] : data_word[15:8];
        // Only data octets pass the scrambler
        if (cfg.scr_en) begin
          cur.val     = scr_res[7:0];
          scr_used    = 1'b1;
          next_scr_st = scr_res[22:8];
        end
      end
      default: ;
    endcase
    if (cfg.mode == MODE_K285) begin
      cur         = '{is_k: 1'b1, val: K28_5};
      scr_used    = 1'b0;
      next_scr_st = scr_st;
    end else if (cfg.mode == MODE_D215) begin
      cur         = '{is_k: 1'b0, val: D21_5};
      scr_used    = 1'b0;
      next_scr_st = scr_st;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scr_st <= SCR_SEED;
    end else begin
      scr_st <= next_scr_st;
    end
  end

  // ****************************************************************
  // Line coding and lane output
  // ****************************************************************
  // Encode after scrambling
  assign enc     = enc_8b10b(cur, rd);
  assign prbs_nx = prbs_word(prbs_st, cfg.mode);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd              <= 1'b0;
      prbs_st         <= PRBS_SEED;
      lane_symbol_out <= SYM_K28_5_N;
    // Raw PRBS bits bypass the encoder
    end else if (is_prbs(cfg.mode)) begin
      prbs_st         <= prbs_nx[32:10];
      lane_symbol_out <= prbs_nx[9:0];
    end else begin
      rd              <= enc[10];
      lane_symbol_out <= enc[9:0];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  k_in_range_a: assert property (
    cfg.k_frames >= K_MIN && cfg.k_frames <= K_MAX)
    else $error("K outside legal range");

  fchk_value_a: assert property (
    state == ST_ILA && mf_cnt == ILA_CFG_MF && oct_cnt == ILA_FCHK_POS
    && cfg.mode == MODE_NORMAL |->
    cur.val == 8'(FCHK_BASE + {3'h0, k_m1} + {7'h0, cfg.scr_en}))
    else $error("ILA checksum wrong");

  cgs_k285_a: assert property (
    state == ST_CGS && cfg.mode == MODE_NORMAL |=>
    lane_symbol_out == SYM_K28_5_N || lane_symbol_out == SYM_K28_5_P)
    else $error("CGS symbol is not K28.5");

  short_sync_a: assert property (
    state == ST_DATA && !sync_req && !realign |=> state == ST_DATA)
    else $error("Link dropped without request");

  held_sync_a: assert property (
    (!sync_s)[*8] ##1 !sync_s && !realign |=> state == ST_CGS)
    else $error("Held request did not break link");

  ila_start_a: assert property (
    state == ST_CGS ##1 state == ST_ILA |->
    $past(lmfc_last) && oct_cnt == ILA_R_POS && mf_cnt == 2'h0)
    else $error("ILA started off LMFC boundary");

  ila_length_a: assert property (
    state == ST_ILA ##1 state == ST_DATA |->
    $past(mf_cnt) == ILA_LAST_MF && $past(lmfc_last))
    else $error("ILA not four multiframes");

  realign_a: assert property (
    realign |=> oct_cnt == SYSREF_LMFC_NEXT && state == ST_CGS)
    else $error("SYSREF realignment wrong");

  ila_unscr_a: assert property (
    state != ST_DATA |-> !scr_used && next_scr_st == scr_st)
    else $error("Scrambler used outside data");

  d215_pat_a: assert property (
    cfg.mode == MODE_D215 |=> lane_symbol_out == SYM_D21_5)
    else $error("D21.5 pattern wrong");

  ila_cycle_c: cover property (
    state == ST_CGS ##1 state == ST_ILA ##[1:600] state == ST_DATA);
  realign_c:   cover property (state == ST_DATA ##1 realign);
  sync_brk_c:  cover property (state == ST_DATA ##1 sync_req);
  ila_rpt_c:   cover property (
    cfg.mode == MODE_ILA_RPT && state == ST_ILA && lmfc_last &&
    mf_cnt == ILA_LAST_MF);

endmodule

// ==== jtx_link_tb_top.sv ====
`timescale 1ns/1ps
module jtx_link_tb_top import jtx_pkg::*;;
  logic        clk = 0, rst_b = 0, sref = 0, go = 0, wr = 0, rd = 0;
  logic [7:0]  hold = 0, addr = 0;
  logic [31:0] wd = 0, q;
  wire logic   sync_n, take, up;
  wire logic [31:0] rdat;
  wire logic [9:0]  sym;
  logic [9:0]  s0;
  int          err_count = 0, tests_run = 0, n;
  jtx_rx_model u_jtx_rx_model (.sys_clk_in(clk), .rst_b_in(rst_b),
    .start_in(go), .hold_in(hold), .sync_n_out(sync_n));
  jtx_link u_jtx_link (.sys_clk_in(clk), .rst_b_in(rst_b),
    .sysref_in(sref), .link_sync_request_n_in(sync_n),
    .sample_data_in(16'h0000), .sample_take_out(take),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .lane_symbol_out(sym),
    .link_up_out(up));
  // ****************************************
  // Bus and check helpers
  // ****************************************
  initial forever #2.5 clk = ~clk;
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task wrr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask
  task rdr(logic [7:0] a);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 q = rdat;
  endtask
  task wt(logic e);
    n = 0;
    while (up !== e && n < 500) begin @(posedge clk); #1; n++; end
    if (n == 500) chk("wait", 1, 0);
  endtask
  task t_regs;
    rdr(REG_CTRL); chk("ctrl", 0, q);
    rdr(REG_KCFG); chk("k", 32, q);
    rdr(8'h10); chk("unmapped", 0, q);
    wrr(REG_KCFG, 3); rdr(REG_KCFG); chk("kclamp", 9, q);
  endtask
  task t_sync;
    @(posedge clk) begin hold <= 3; go <= 1; end
    @(posedge clk) go <= 0;
    repeat (30) @(posedge clk);
    chk("short", 1, up);
    @(posedge clk) begin hold <= 20; go <= 1; end
    @(posedge clk) go <= 0;
    wt(0); chk("drop", 1, n < 16);
    @(posedge clk);
    #1 chk("k285", 1, sym === SYM_K28_5_N || sym === SYM_K28_5_P);
    while (sync_n !== 1) @(posedge clk);
    wt(1); chk("ila", 1, n >= 72 && n <= 96);
  endtask
  task t_sref;
    repeat (2) begin
      @(posedge clk) sref <= 1;
      @(posedge clk) sref <= 0;
    end
    wt(0); chk("realign", 1, n < 12);
    rdr(REG_STAT); chk("sticky", 1, q[5]);
    wt(1);
    wrr(REG_STAT, 32'h20); rdr(REG_STAT); chk("clr", 0, q[5]);
  endtask
  task t_modes;
    wrr(REG_CTRL, 32'h10); repeat (3) @(posedge clk);
    #1 chk("d215", SYM_D21_5, sym);
    wrr(REG_CTRL, 32'h20); repeat (3) @(posedge clk);
    #1 chk("k28", 1, sym === SYM_K28_5_N || sym === SYM_K28_5_P);
    for (int m = 5; m < 8; m++) begin
      wrr(REG_CTRL, m << 4); repeat (4) @(posedge clk);
      s0 = sym; @(posedge clk);
      #1 chk("prbs", 1, sym !== s0);
    end
  endtask
  task t_more;
    wrr(REG_CTRL, 32'h31); rdr(REG_CTRL); chk("scr", 32'h31, q);
    repeat (2) begin
      @(posedge clk) sref <= 1;
      @(posedge clk) sref <= 0;
    end
    repeat (200) @(posedge clk);
    #1 chk("ilarpt", 0, up);
    wrr(REG_CTRL, 32'h40); repeat (2) @(posedge clk);
    #1 chk("ramp", 0, take);
  endtask
  task end_of_test;
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    t_regs;
    wt(1); chk("up", 1, up);
    t_sync;
    t_sref;
    t_modes;
    t_more;
    end_of_test();
  end
endmodule

// ==== jtx_pkg.sv ====
// Functional notes
// - Frame layout is fixed; F, S and HD have no programmable setting.
// - ADJCNT, ADJDIR, BID, CF, CS, DID, HD, PHADJ, reserved are zero.
// - F is two frames octets, sent as encoded one.
// - K comes from a register, held within 9..32, sent as 8..31.
// - One lane and one sample per frame, both sent encoded as zero.
// - N and N' are sixteen, both sent encoded as fifteen.
// - JESD204 version and subclass version are both sent as one.
// - Converters per device field is sent as one.
// - SCR follows the register; checksum is 34 plus K-1 plus SCR.
// - F, K, L, M, N, N', S are sent minus one.
// - Data scrambling only when enabled; off after reset.
// - ILA is never scrambled; early descrambler sync is harmless.
// - D21.5 test mode sends a continuous 1010 bit pattern.
// - Test modes for endless K28.5 and for endlessly repeated ILA.
// - Ramp mode sends a 16-bit ramp with programmable step after ILA.
// - PRBS7, PRBS15 and PRBS23 lane sequences are selectable.
// - Data follows frame alignment, code group sync and ILA only.
// - Every SYSREF rise aligns frame clock and LMFC with a fixed delay.
// - A phase change from realignment drops the link.
// - Frame clock and LMFC free-run from reset with arbitrary phase.
// - Sync request must be low four frames; K28.5 is sent meanwhile.
// - ILA starts at the next LMFC after release; four multiframes.
// - Two 8b/10b octets per sample on the single lane.
package jtx_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_KCFG         = 8'h04;
  localparam logic [7:0]  REG_RAMP         = 8'h08;
  localparam logic [7:0]  REG_STAT         = 8'h0c;
  localparam int          CTRL_SCR_BIT     = 0;
  localparam int          CTRL_MODE_LSB    = 4;
  localparam int          MODE_W           = 3;
  localparam int          K_W              = 6;
  localparam int          STEP_W           = 16;
  localparam int          STAT_STATE_LSB   = 0;
  localparam int          STAT_MF_LSB      = 2;
  localparam int          STAT_SYNC_BIT    = 4;
  localparam int          STAT_REALIGN_BIT = 5;
  localparam logic [5:0]  K_MIN            = 6'h09;
  localparam logic [5:0]  K_MAX            = 6'h20;
  localparam logic [5:0]  K_RST            = 6'h20;
  localparam logic [5:0]  K_ENC_OFS        = 6'h01;
  localparam logic [15:0] RAMP_RST         = 16'h0001;

  // ****************************************************************
  // Link timing
  // ****************************************************************
  localparam int          OCT_PER_FRAME    = 2;
  localparam int          SYNC_MIN_FRAMES  = 4;
  localparam logic [3:0]  SYNC_MIN_CYC     =
    4'(SYNC_MIN_FRAMES * OCT_PER_FRAME);
  localparam logic [5:0]  SYSREF_LMFC_DLY  = 6'h02;
  localparam logic [5:0]  SYSREF_LMFC_NEXT = 6'(SYSREF_LMFC_DLY + 6'h01);
  localparam logic [1:0]  ILA_LAST_MF      = 2'h3;
  localparam logic [1:0]  ILA_CFG_MF       = 2'h1;
  localparam logic [5:0]  ILA_R_POS        = 6'h00;
  localparam logic [5:0]  ILA_Q_POS        = 6'h01;
  localparam int          ILA_CFG_START    = 2;
  localparam int          ILA_CFG_OCTETS   = 14;
  localparam logic [5:0]  ILA_FCHK_POS     =
    6'(ILA_CFG_START + ILA_CFG_OCTETS - 1);
  localparam logic [14:0] SCR_SEED         = 15'h7fff;
  localparam logic [22:0] PRBS_SEED        = 23'h7fffff;

  // ****************************************************************
  // Characters and ILA fields
  // ****************************************************************
  localparam int          SYM_W            = 10;
  localparam logic [7:0]  K28_0            = 8'h1c;
  localparam logic [7:0]  K28_3            = 8'h7c;
  localparam logic [7:0]  K28_4            = 8'h9c;
  localparam logic [7:0]  K28_5            = 8'hbc;
  localparam logic [7:0]  D21_5            = 8'hb5;
  localparam logic [9:0]  SYM_D21_5        = 10'h2aa;
  localparam logic [9:0]  SYM_K28_5_N      = 10'h0fa;
  localparam logic [9:0]  SYM_K28_5_P      = 10'h305;
  localparam logic [5:0]  K28_6B           = 6'h0f;
  localparam logic [3:0]  ALT7_4B          = 4'h7;
  localparam logic [7:0]  ILA_ZERO         = 8'h00;
  localparam logic [4:0]  ILA_L_ENC        = 5'h00;
  localparam logic [7:0]  ILA_F_ENC        = 8'h01;
  localparam logic [7:0]  ILA_M_ENC        = 8'h01;
  localparam logic [4:0]  ILA_N_ENC        = 5'h0f;
  localparam logic [4:0]  ILA_NP_ENC       = 5'h0f;
  localparam logic [2:0]  ILA_SUBCV        = 3'h1;
  localparam logic [2:0]  ILA_JESDV        = 3'h1;
  localparam logic [4:0]  ILA_S_ENC        = 5'h00;
  localparam logic [7:0]  FCHK_BASE        = 8'h22;
  localparam logic [0:31][5:0] ENC6 = {
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [0:7][3:0] ENC4 = {
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_D215    = 3'b001,
    MODE_K285    = 3'b010,
    MODE_ILA_RPT = 3'b011,
    MODE_RAMP    = 3'b100,
    MODE_PRBS7   = 3'b101,
    MODE_PRBS15  = 3'b110,
    MODE_PRBS23  = 3'b111
  } jtx_mode_t;

  typedef enum logic [1:0] {
    ST_CGS  = 2'b00,
    ST_ILA  = 2'b01,
    ST_DATA = 2'b10
  } jtx_state_t;

  typedef struct packed {
    logic                  scr_en;
    jtx_mode_t             mode;
    logic [K_W-1:0]        k_frames;
    logic [STEP_W-1:0]     ramp_step;
  } jtx_cfg_t;

  typedef struct packed {
    logic       is_k;
    logic [7:0] val;
  } jtx_oct_t;

endpackage

// ==== jtx_rx_model.sv ====
`timescale 1ns/1ps
module jtx_rx_model (
  input  wire logic       sys_clk_in,  // Device clock
  input  wire logic       rst_b_in,    // Async reset
  input  wire logic       start_in,    // Begin request
  input  wire logic [7:0] hold_in,     // Low cycles
  output logic            sync_n_out   // Sync request
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cnt <= 8'h00;
    else if (start_in) cnt <= hold_in;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
  assign sync_n_out = (cnt == 8'h00);
endmodule
